// ==== rtl/aoc_map.vh ====
// register offsets, field positions, reset values and counts for the
// output control register bank; definitions only.
// assumes inclusion by bare name from the design files.
`ifndef AOC_MAP_VH
`define AOC_MAP_VH

// ==========================================================
// register offsets
`define AOC_OFS_CHAN      8'h04
`define AOC_OFS_LOUD      8'h05
`define AOC_OFS_GAIN      8'h06
`define AOC_OFS_FAULT     8'h07

// ==========================================================
// reset values
`define AOC_RST_CHAN      8'h00
`define AOC_RST_LOUD      8'h40
`define AOC_RST_GAIN      8'h11
`define AOC_RST_FAULT     8'h0c

// ==========================================================
// field positions
`define AOC_GAIN_ZRUN_BIT 7
`define AOC_GAIN_RNG_HI   5
`define AOC_GAIN_RNG_LO   4
`define AOC_GAIN_MUTE_BIT 0
`define AOC_FLT_OC_BIT    6
`define AOC_FLT_OT_BIT    5
`define AOC_FLT_MAN_BIT   4
`define AOC_FLT_LIM_HI    3
`define AOC_FLT_LIM_LO    2
`define AOC_FLT_POL_HI    1
`define AOC_FLT_POL_LO    0

// ==========================================================
// codes and counts
`define AOC_LOUD_SILENT   8'hff
`define AOC_POL_BOTH      2'h0
`define AOC_POL_OT        2'h1
`define AOC_POL_OC        2'h2
`define AOC_POL_NONE      2'h3
`define AOC_LIM_UNLIM     2'h3
`define AOC_ZERO_RUN_LEN  2048
`define AOC_RETRY_GAP     1024
`define AOC_FMT_TDM4      3'h2
`define AOC_FMT_TDM8      3'h3
`define AOC_FMT_TDM16     3'h4

`endif

// ==== rtl/aoc_zero_run.v ====
// counter of consecutive zero samples on the picked channel.
// assumes one sample strobe per frame, synchronous to clk_sys.
`timescale 1ns/1ps

module aoc_zero_run
#(
   parameter RUN_LEN = 2048
)
(
   input  wire clk_sys,
   input  wire arst_n,
   input  wire soft_restart,
   input  wire smp_valid,
   input  wire smp_zero,
   output reg  run_hit_q
);

   reg [11:0] cnt_q;

   // ======================================================
   // run counter; any nonzero sample restarts the run
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_q     <= 12'h000;
         run_hit_q <= 1'b0;
      end
      else if (soft_restart)
      begin
         cnt_q     <= 12'h000;
         run_hit_q <= 1'b0;
      end
      else if (smp_valid)
      begin
         if (!smp_zero)
         begin
            cnt_q     <= 12'h000;
            run_hit_q <= 1'b0;
         end
         else if (cnt_q == RUN_LEN[11:0] - 12'h001)
            run_hit_q <= 1'b1;
         else
            cnt_q <= cnt_q + 12'h001;
      end
   end

endmodule

// ==== rtl/aoc_fault_retry.v ====
// fault recovery sequencer: paces automatic retries and passes manual ones when policy is 11.
// assumes fault levels already sampled on clk_sys.
`timescale 1ns/1ps
`include "aoc_map.vh"

module aoc_fault_retry
#(
   parameter GAP = 1024
)
(
   input  wire       clk_sys,
   input  wire       arst_n,
   input  wire       soft_restart,
   input  wire       oc_flag,
   input  wire       ot_flag,
   input  wire [1:0] policy,
   input  wire [1:0] limit,
   input  wire       manual_trig,
   output reg        retry_q
);

   localparam ST_IDLE  = 3'b001;
   localparam ST_WAIT  = 3'b010;
   localparam ST_SPENT = 3'b100;

   reg [2:0]  st_q;
   reg [2:0]  st_d;
   reg [10:0] gap_q;
   reg [2:0]  tries_q;
   reg        covered;
   reg        limit_hit;

   // ======================================================
   // which faults the policy recovers, and the attempt ceiling
   always @*
   begin
      case (policy)
         `AOC_POL_BOTH: covered = oc_flag | ot_flag;
         `AOC_POL_OT:   covered = ot_flag & ~oc_flag;
         `AOC_POL_OC:   covered = oc_flag & ~ot_flag;
         default:       covered = 1'b0;
      endcase
      case (limit)
         2'h0:    limit_hit = (tries_q == 3'd1);
         2'h1:    limit_hit = (tries_q == 3'd3);
         2'h2:    limit_hit = (tries_q == 3'd7);
         default: limit_hit = 1'b0;
      endcase
   end

   // ======================================================
   // next state: wait a gap while a covered fault stands, then retry
   always @*
   begin
      st_d = st_q;
      case (st_q)
         ST_IDLE:  if (covered) st_d = limit_hit ? ST_SPENT : ST_WAIT;
         ST_WAIT:  if (!covered) st_d = ST_IDLE;
                   else if (gap_q == GAP[10:0] - 11'h001) st_d = ST_IDLE;
         ST_SPENT: if (!(oc_flag | ot_flag)) st_d = ST_IDLE;
         default:  st_d = ST_IDLE;
      endcase
   end

   // ======================================================
   // state, gap timer, attempt count; tries reset once faults clear
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_q    <= ST_IDLE;
         gap_q   <= 11'h000;
         tries_q <= 3'h0;
         retry_q <= 1'b0;
      end
      else if (soft_restart)
      begin
         st_q    <= ST_IDLE;
         gap_q   <= 11'h000;
         tries_q <= 3'h0;
         retry_q <= 1'b0;
      end
      else
      begin
         st_q    <= st_d;
         gap_q   <= (st_q == ST_WAIT) ? gap_q + 11'h001 : 11'h000;
         retry_q <= 1'b0;
         if (st_q == ST_WAIT && st_d == ST_IDLE && covered)
         begin
            retry_q <= 1'b1;
            if (tries_q != 3'h7)
               tries_q <= tries_q + 3'h1;
         end
         else if (manual_trig && policy == `AOC_POL_NONE)
            retry_q <= 1'b1;
         else if (!(oc_flag | ot_flag))
            tries_q <= 3'h0;
      end
   end

endmodule

// ==== rtl/aoc_regs.v ====
// output control register bank with channel pick, loudness scaling,
// silencing and fault recovery control.
// assumes a two-wire bus controller giving one-cycle read and write
// strobes, and a serial receiver giving one strobe per received slot.
`timescale 1ns/1ps
`include "aoc_map.vh"

// Operation
// - four-bit code routes channel n to output
// - loudness resets 0x40, unity gain, 0 gives +24dB
// - 0.375 dB steps down; 0xff silences
// - active zero-run silence after 2048 zeros
// - two-bit field selects modulator range
// - global silence bit mutes output
// - gain register resets to 0x11
// - read-only overcurrent and overheat flags
// - manual retry only when policy is 11
// - retry limit one, three, seven, unlimited
// - policy selects which faults auto-recover
// - fault register resets to 0x0c
// - soft restart returns every writable field to reset
module aoc_regs
#(
   parameter SW        = 24,
   parameter ZRUN      = `AOC_ZERO_RUN_LEN,
   parameter RETRY_GAP = `AOC_RETRY_GAP
)
(
   input  wire          clk_sys,
   input  wire          arst_n,
   input  wire          soft_restart,
   input  wire          reg_wr,
   input  wire          reg_rd,
   input  wire [7:0]    reg_addr,
   input  wire [7:0]    reg_wdata,
   output reg  [7:0]    reg_rdata_q,
   input  wire [2:0]    frame_fmt,
   input  wire          slot_valid,
   input  wire [3:0]    slot_index,
   input  wire [SW-1:0] slot_data,
   input  wire          oc_fault,
   input  wire          ot_fault,
   output reg           out_valid_q,
   output reg  [SW-1:0] out_sample_q,
   output reg  [1:0]    range_sel_q,
   output wire          retry_q
);

   localparam PW = SW + 17;
   localparam WW = PW + 8;

   // register fields
   reg  [3:0]           channel_pick_q;
   reg  [7:0]           loudness_code_q;
   reg                  zero_run_silence_q;
   reg                  master_mute_q;
   reg                  overcurrent_flag_q;
   reg                  overheat_flag_q;
   reg  [1:0]           retry_limit_q;
   reg  [1:0]           auto_retry_policy_q;
   reg                  manual_retry_trigger_q;
   // datapath
   reg                  pick_valid_q;
   reg  signed [SW-1:0] pick_data_q;
   reg                  mul_valid_q;
   reg  signed [PW-1:0] prod_q;
   reg  [3:0]           mul_exp_q;
   reg                  mul_silent_q;
   reg  [4:0]           nslots;
   reg  signed [WW-1:0] wide;
   reg  signed [WW-1:0] shifted;
   wire                 zero_hit;
   wire                 chan_ok;
   wire                 last_slot;

   // ======================================================
   // fine step of the loudness curve: 2^(-k/16) in q1.15
   function [15:0] mant;
      input [3:0] k;
      begin
         case (k)
            4'h0:    mant = 16'h8000;
            4'h1:    mant = 16'h7a93;
            4'h2:    mant = 16'h7560;
            4'h3:    mant = 16'h7066;
            4'h4:    mant = 16'h6ba2;
            4'h5:    mant = 16'h6712;
            4'h6:    mant = 16'h62b4;
            4'h7:    mant = 16'h5e84;
            4'h8:    mant = 16'h5a82;
            4'h9:    mant = 16'h56ac;
            4'ha:    mant = 16'h52ff;
            4'hb:    mant = 16'h4f7b;
            4'hc:    mant = 16'h4c1c;
            4'hd:    mant = 16'h48e2;
            4'he:    mant = 16'h45cb;
            default: mant = 16'h42d5;
         endcase
      end
   endfunction

   // ======================================================
   // clamp a widened sample back to the output width
   function [SW-1:0] sat;
      input signed [WW-1:0] v;
      begin
         if (v > $signed({{(WW-SW+1){1'b0}}, {(SW-1){1'b1}}}))
            sat = {1'b0, {(SW-1){1'b1}}};
         else if (v < $signed({{(WW-SW+1){1'b1}}, {(SW-1){1'b0}}}))
            sat = {1'b1, {(SW-1){1'b0}}};
         else
            sat = v[SW-1:0];
      end
   endfunction

   // ======================================================
   // register writes; soft restart has the same effect as reset
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         channel_pick_q         <= 4'h0;
         loudness_code_q        <= `AOC_RST_LOUD;
         zero_run_silence_q     <= 1'b0;
         range_sel_q            <= 2'h1;
         master_mute_q          <= 1'b1;
         retry_limit_q          <= 2'h3;
         auto_retry_policy_q    <= 2'h0;
         manual_retry_trigger_q <= 1'b0;
      end
      else if (soft_restart)
      begin
         channel_pick_q         <= 4'h0;
         loudness_code_q        <= `AOC_RST_LOUD;
         zero_run_silence_q     <= 1'b0;
         range_sel_q            <= 2'h1;
         master_mute_q          <= 1'b1;
         retry_limit_q          <= 2'h3;
         auto_retry_policy_q    <= 2'h0;
         manual_retry_trigger_q <= 1'b0;
      end
      else
      begin
         manual_retry_trigger_q <= 1'b0;
         if (reg_wr)
         begin
            case (reg_addr)
               `AOC_OFS_CHAN:
                  channel_pick_q <= reg_wdata[3:0];
               `AOC_OFS_LOUD:
                  loudness_code_q <= reg_wdata;
               `AOC_OFS_GAIN:
               begin
                  zero_run_silence_q <= reg_wdata[`AOC_GAIN_ZRUN_BIT];
                  range_sel_q <=
                     reg_wdata[`AOC_GAIN_RNG_HI:`AOC_GAIN_RNG_LO];
                  master_mute_q <= reg_wdata[`AOC_GAIN_MUTE_BIT];
               end
               `AOC_OFS_FAULT:
               begin
                  manual_retry_trigger_q <=
                     reg_wdata[`AOC_FLT_MAN_BIT];
                  retry_limit_q <=
                     reg_wdata[`AOC_FLT_LIM_HI:`AOC_FLT_LIM_LO];
                  auto_retry_policy_q <=
                     reg_wdata[`AOC_FLT_POL_HI:`AOC_FLT_POL_LO];
               end
               default: ;
            endcase
         end
      end
   end

   // ======================================================
   // fault levels are live status, not latched
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         overcurrent_flag_q <= 1'b0;
         overheat_flag_q    <= 1'b0;
      end
      else
      begin
         overcurrent_flag_q <= oc_fault;
         overheat_flag_q    <= ot_fault;
      end
   end

   // ======================================================
   // read data, one cycle after the strobe; unmapped reads give zero
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         reg_rdata_q <= 8'h00;
      else if (reg_rd)
      begin
         case (reg_addr)
            `AOC_OFS_CHAN:  reg_rdata_q <= {4'h0, channel_pick_q};
            `AOC_OFS_LOUD:  reg_rdata_q <= loudness_code_q;
            `AOC_OFS_GAIN:  reg_rdata_q <= {zero_run_silence_q, 1'b0,
                                            range_sel_q, 3'h0,
                                            master_mute_q};
            `AOC_OFS_FAULT: reg_rdata_q <= {1'b0, overcurrent_flag_q,
                                            overheat_flag_q, 1'b0,
                                            retry_limit_q,
                                            auto_retry_policy_q};
            default:        reg_rdata_q <= 8'h00;
         endcase
      end
   end

   // ======================================================
   // slots carried by the current frame format
   always @*
   begin
      case (frame_fmt)
         `AOC_FMT_TDM4:  nslots = 5'd4;
         `AOC_FMT_TDM8:  nslots = 5'd8;
         `AOC_FMT_TDM16: nslots = 5'd16;
         default:        nslots = 5'd2;
      endcase
   end

   assign chan_ok   = ({1'b0, channel_pick_q} < nslots);
   assign last_slot = ({1'b0, slot_index} == nslots - 5'd1);

   // ======================================================
   // channel pick; a pick past the frame emits silence at frame end
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pick_valid_q <= 1'b0;
         pick_data_q  <= {SW{1'b0}};
      end
      else
      begin
         pick_valid_q <= 1'b0;
         if (slot_valid && chan_ok && slot_index == channel_pick_q)
         begin
            pick_valid_q <= 1'b1;
            pick_data_q  <= slot_data;
         end
         else if (slot_valid && !chan_ok && last_slot)
         begin
            pick_valid_q <= 1'b1;
            pick_data_q  <= {SW{1'b0}};
         end
      end
   end

   aoc_zero_run #(
      .RUN_LEN      (ZRUN)
   ) u_zero_run (
      .clk_sys      (clk_sys),
      .arst_n       (arst_n),
      .soft_restart (soft_restart),
      .smp_valid    (pick_valid_q),
      .smp_zero     (pick_data_q == {SW{1'b0}}),
      .run_hit_q    (zero_hit)
   );

   // ======================================================
   // multiply by the fine step; coarse 6 dB shift follows
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mul_valid_q  <= 1'b0;
         prod_q       <= {PW{1'b0}};
         mul_exp_q    <= 4'h0;
         mul_silent_q <= 1'b1;
      end
      else
      begin
         mul_valid_q  <= pick_valid_q;
         prod_q       <= pick_data_q * $signed({1'b0,
                         mant(loudness_code_q[3:0])});
         mul_exp_q    <= loudness_code_q[7:4];
         // hard zero instead of a ramp: keeps the path short, but a
         // mute mid-waveform can click
         mul_silent_q <= (loudness_code_q == `AOC_LOUD_SILENT)
                         | master_mute_q
                         | (zero_hit & ~zero_run_silence_q);
      end
   end

   // gain 2^(4 - exp) x fine step; exp 4 with step 0 is unity
   always @*
   begin
      wide    = {{4{prod_q[PW-1]}}, prod_q, 4'h0};
      shifted = wide >>> (5'd15 + {1'b0, mul_exp_q});
   end

   // ======================================================
   // output stage
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         out_valid_q  <= 1'b0;
         out_sample_q <= {SW{1'b0}};
      end
      else
      begin
         out_valid_q <= mul_valid_q;
         if (mul_valid_q)
            out_sample_q <= mul_silent_q ? {SW{1'b0}} : sat(shifted);
      end
   end

   aoc_fault_retry #(
      .GAP          (RETRY_GAP)
   ) u_fault_retry (
      .clk_sys      (clk_sys),
      .arst_n       (arst_n),
      .soft_restart (soft_restart),
      .oc_flag      (overcurrent_flag_q),
      .ot_flag      (overheat_flag_q),
      .policy       (auto_retry_policy_q),
      .limit        (retry_limit_q),
      .manual_trig  (manual_retry_trigger_q),
      .retry_q      (retry_q)
   );

endmodule

// ==== verif/aoc_regs_properties.sv ====
// checker: timing properties of the output control register bank.
// assumes it is bound onto aoc_regs and sees only that module's ports.
`timescale 1ns/1ps

module aoc_regs_chk
#(
   parameter SW        = 24,
   parameter ZRUN      = 2048,
   parameter RETRY_GAP = 1024
)
(
   input wire          clk_sys,
   input wire          arst_n,
   input wire          soft_restart,
   input wire          reg_wr,
   input wire          reg_rd,
   input wire [7:0]    reg_addr,
   input wire [7:0]    reg_wdata,
   input wire [7:0]    reg_rdata_q,
   input wire [2:0]    frame_fmt,
   input wire          slot_valid,
   input wire [3:0]    slot_index,
   input wire [SW-1:0] slot_data,
   input wire          oc_fault,
   input wire          ot_fault,
   input wire          out_valid_q,
   input wire [SW-1:0] out_sample_q,
   input wire [1:0]    range_sel_q,
   input wire          retry_q
);
   reg  [7:0] loud_q;
   reg  [7:0] gain_q;
   reg  [1:0] pol_q;
   wire       mute_b = gain_q[0];
   wire       wr_flt = reg_wr && reg_addr == 8'h07 && !soft_restart;

   // ======================================================
   // shadow copies; a restart returns them to reset like the bank
   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         {loud_q, gain_q, pol_q} <= {8'h40, 8'h11, 2'h0};
      else if (soft_restart)
         {loud_q, gain_q, pol_q} <= {8'h40, 8'h11, 2'h0};
      else if (reg_wr)
      begin
         if (reg_addr == 8'h05)
            loud_q <= reg_wdata;
         if (reg_addr == 8'h06)
            gain_q <= reg_wdata;
         if (reg_addr == 8'h07)
            pol_q <= reg_wdata[1:0];
      end
   end

   // ======================================================
   // properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   property p_unmapped;
      reg_rd && !reg_wr && (reg_addr < 8'h04 || reg_addr > 8'h07)
      |=> reg_rdata_q == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");

   property p_flags;
      reg_rd && !reg_wr && !soft_restart && reg_addr == 8'h07 |=>
      reg_rdata_q[7:4] == {1'b0, $past(oc_fault, 2), $past(ot_fault, 2), 1'b0};
   endproperty
   a_flags: assert property (p_flags)
      else $error("fault flags read wrong");

   property p_range;
      reg_wr && reg_addr == 8'h06 && !soft_restart
      |=> ##[0:1] range_sel_q == gain_q[5:4];
   endproperty
   a_range: assert property (p_range)
      else $error("range select not following write");

   property p_out_cause;
      out_valid_q |-> $past(slot_valid, 3);
   endproperty
   a_out_cause: assert property (p_out_cause)
      else $error("output without slot three cycles earlier");

   property p_silent;
      out_valid_q && loud_q == 8'hff && $past(loud_q, 3) == 8'hff
      |-> out_sample_q == '0;
   endproperty
   a_silent: assert property (p_silent)
      else $error("silent code let sound through");

   property p_mute;
      out_valid_q && mute_b && $past(mute_b, 3) |-> out_sample_q == '0;
   endproperty
   a_mute: assert property (p_mute)
      else $error("mute bit let sound through");

   property p_manual;
      wr_flt && reg_wdata[4] && reg_wdata[1:0] == 2'h3 |-> ##[2:3] retry_q;
   endproperty
   a_manual: assert property (p_manual)
      else $error("manual retry missing");

   property p_no_auto;
      pol_q == 2'h3 && $past(pol_q, 3) == 2'h3 && !$past(reg_wr, 2) &&
      !$past(reg_wr, 3) |-> !retry_q;
   endproperty
   a_no_auto: assert property (p_no_auto)
      else $error("retry while recovery disabled");

   c_out: cover property (out_valid_q);
   c_manual: cover property (wr_flt && reg_wdata[4]);
   c_retry: cover property (retry_q);
endmodule

bind aoc_regs aoc_regs_chk
#(
   .SW        (SW),
   .ZRUN      (ZRUN),
   .RETRY_GAP (RETRY_GAP)
)
u_chk
(
   .clk_sys(clk_sys), .arst_n(arst_n), .soft_restart(soft_restart),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
   .frame_fmt(frame_fmt), .slot_valid(slot_valid),
   .slot_index(slot_index), .slot_data(slot_data),
   .oc_fault(oc_fault), .ot_fault(ot_fault),
   .out_valid_q(out_valid_q), .out_sample_q(out_sample_q),
   .range_sel_q(range_sel_q), .retry_q(retry_q)
);

// ==== verif/aoc_host.sv ====
// host model: the two-wire controller side, one-cycle register strobes.
// assumes clk_sys from the bench; drives only at the falling edge.
`timescale 1ns/1ps

module aoc_host
(
   input  wire       clk_sys,
   input  wire [7:0] reg_rdata_q,
   output reg        reg_wr,
   output reg        reg_rd,
   output reg  [7:0] reg_addr,
   output reg  [7:0] reg_wdata
);
   // ======================================================
   // bus idle from time zero
   initial
   begin
      {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h00000;
   end

   // one strobe cycle; released address and data turn to junk so a
   // late sample in the bank cannot pass for a good one
   task xfer(input w, input [7:0] a, input [7:0] d, output [7:0] q);
   begin
      @(negedge clk_sys);
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
      @(negedge clk_sys);
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
      q = reg_rdata_q;
   end
   endtask
endmodule

// ==== verif/tb.sv ====
// bench: drives the output control bank through the host model and a
// slot source; assumes host model and checker are compiled first.
`timescale 1ns/1ps

module tb;
   localparam SW = 24;
   reg           clk_sys = 1'b0;
   reg           arst_n = 1'b0;
   reg           soft_restart = 1'b0;
   reg  [2:0]    frame_fmt = 3'h4;
   reg           slot_valid = 1'b0;
   reg  [3:0]    slot_index = 4'h0;
   reg  [SW-1:0] slot_data = 24'h000000;
   reg           oc_fault = 1'b0;
   reg           ot_fault = 1'b0;
   wire          reg_wr;
   wire          reg_rd;
   wire [7:0]    reg_addr;
   wire [7:0]    reg_wdata;
   wire [7:0]    reg_rdata_q;
   wire          out_valid_q;
   wire [SW-1:0] out_sample_q;
   wire [1:0]    range_sel_q;
   wire          retry_q;
   integer       miscompares = 0;
   integer       checks = 0;
   integer       got_n = 0;
   integer       retries = 0;
   integer       i;
   reg  [SW-1:0] got;
   reg  [7:0]    q;

   // ======================================================
   // clock, design, host; short counts keep the run brief
   always #5 clk_sys = ~clk_sys;

   aoc_regs #(.SW(SW), .ZRUN(8), .RETRY_GAP(4)) dut
   (
      .clk_sys(clk_sys), .arst_n(arst_n), .soft_restart(soft_restart),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
      .frame_fmt(frame_fmt), .slot_valid(slot_valid),
      .slot_index(slot_index), .slot_data(slot_data),
      .oc_fault(oc_fault), .ot_fault(ot_fault),
      .out_valid_q(out_valid_q), .out_sample_q(out_sample_q),
      .range_sel_q(range_sel_q), .retry_q(retry_q)
   );

   aoc_host u_host
   (
      .clk_sys(clk_sys), .reg_rdata_q(reg_rdata_q), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata)
   );

   // collect output and retry strobes; values are those before the edge
   always @(posedge clk_sys)
   begin
      if (out_valid_q === 1'b1)
         {got, got_n} = {out_sample_q, got_n + 1};
      if (retry_q === 1'b1)
         retries = retries + 1;
   end

   // ======================================================
   // shared helpers
   function [SW-1:0] sv(input [3:0] k);
      sv = {11'h000, {1'b0, k} + 5'h01, 8'h00};
   endfunction

   task conclude;
   begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask

   task chk(input string what, input [31:0] seen, input [31:0] exp);
   begin
      checks = checks + 1;
      if (seen !== exp)
      begin
         miscompares = miscompares + 1;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   end
   endtask

   task wr(input [7:0] a, input [7:0] d);
   begin
      u_host.xfer(1'b1, a, d, q);
   end
   endtask

   task rchk(input [7:0] a, input [7:0] e);
   begin
      u_host.xfer(1'b0, a, 8'h00, q);
      chk("rdata", {24'h000000, q}, {24'h000000, e});
   end
   endtask

   // one frame of n back-to-back slots; picked sample compared to e
   task frame(input [2:0] f, input integer n, input [3:0] p, input z,
              input [SW-1:0] e);
      integer k;
   begin
      frame_fmt = f;
      wr(8'h04, {4'h0, p});
      got_n = 0;
      for (k = 0; k < n; k = k + 1)
      begin
         @(negedge clk_sys);
         {slot_valid, slot_index} = {1'b1, k[3:0]};
         slot_data = z ? 24'h000000 : sv(k[3:0]);
      end
      @(negedge clk_sys);
      {slot_valid, slot_data} = {1'b0, ~slot_data};
      for (k = 0; k < 30 && got_n == 0; k = k + 1)
         @(negedge clk_sys);
      if (got_n == 0)
      begin
         miscompares = miscompares + 1;
         conclude;
      end
      chk("sample", {8'h00, got}, {8'h00, e});
   end
   endtask

   // fault pattern f held while counting retries, clamped at eight
   task auto(input [7:0] c, input [1:0] f, input [31:0] e);
   begin
      wr(8'h07, c);
      {oc_fault, ot_fault, retries} = {f, 32'h0};
      repeat (150) @(negedge clk_sys);
      {oc_fault, ot_fault} = 2'b00;
      chk("retries", (retries > 7) ? 32'h8 : retries, e);
      repeat (10) @(negedge clk_sys);
   end
   endtask

   // ======================================================
   // scenarios
   task t_regs;
   begin
      rchk(8'h04, 8'h00);
      rchk(8'h05, 8'h40);
      rchk(8'h06, 8'h11);
      rchk(8'h07, 8'h0c);
      rchk(8'h08, 8'h00);
      wr(8'h03, 8'h5a);
      rchk(8'h03, 8'h00);
      wr(8'h04, 8'hff);
      rchk(8'h04, 8'h0f);
      wr(8'h06, 8'hff);
      rchk(8'h06, 8'hb1);
      wr(8'h05, 8'h12);
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(8'h06, {2'h2, i[1:0], 4'h0});
         @(negedge clk_sys);
         chk("range", {30'h0, range_sel_q}, i[31:0]);
      end
      soft_restart = 1'b1;
      @(negedge clk_sys);
      soft_restart = 1'b0;
      chk("range", {30'h0, range_sel_q}, 32'h1);
      rchk(8'h04, 8'h00);
      rchk(8'h05, 8'h40);
      rchk(8'h06, 8'h11);
   end
   endtask

   task t_route;
   begin
      wr(8'h06, 8'h90);
      for (i = 0; i < 16; i = i + 1)
         frame(3'h4, 16, i[3:0], 1'b0, sv(i[3:0]));
      for (i = 0; i < 2; i = i + 1)
         frame(3'h0, 2, i[3:0], 1'b0, sv(i[3:0]));
      frame(3'h2, 4, 4'h3, 1'b0, sv(4'h3));
      frame(3'h2, 4, 4'h9, 1'b0, 24'h000000);
      wr(8'h06, 8'h10);
      // the silent pick above is the first zero of the run of eight
      for (i = 0; i < 7; i = i + 1)
         frame(3'h2, 4, 4'h1, 1'b1, 24'h000000);
      frame(3'h2, 4, 4'h1, 1'b0, 24'h000000);
      frame(3'h2, 4, 4'h1, 1'b0, sv(4'h1));
      wr(8'h05, 8'h00);
      frame(3'h2, 4, 4'h1, 1'b0, 24'h002000);
      wr(8'h05, 8'h30);
      frame(3'h2, 4, 4'h1, 1'b0, 24'h000400);
      wr(8'h05, 8'h50);
      frame(3'h2, 4, 4'h1, 1'b0, 24'h000100);
      wr(8'h05, 8'hff);
      frame(3'h2, 4, 4'h1, 1'b0, 24'h000000);
      wr(8'h05, 8'h40);
      wr(8'h06, 8'h11);
      frame(3'h2, 4, 4'h1, 1'b0, 24'h000000);
   end
   endtask

   task t_faults;
   begin
      wr(8'h07, 8'h03);
      oc_fault = 1'b1;
      rchk(8'h07, 8'h43);
      {oc_fault, ot_fault} = 2'b01;
      rchk(8'h07, 8'h23);
      retries = 0;
      wr(8'h07, 8'h13);
      repeat (8) @(negedge clk_sys);
      chk("manual", retries, 32'h1);
      {ot_fault, retries} = {1'b0, 32'h0};
      wr(8'h07, 8'h10);
      repeat (8) @(negedge clk_sys);
      chk("manual", retries, 32'h0);
      auto(8'h02, 2'b10, 32'h1);
      auto(8'h04, 2'b10, 32'h3);
      auto(8'h09, 2'b01, 32'h7);
      auto(8'h0c, 2'b01, 32'h8);
      auto(8'h05, 2'b10, 32'h0);
      auto(8'h06, 2'b01, 32'h0);
      auto(8'h0f, 2'b11, 32'h0);
   end
   endtask

   // ======================================================
   // main sequence
   initial
   begin
      repeat (16) @(negedge clk_sys);
      arst_n = 1'b1;
      t_regs;
      t_route;
      t_faults;
      conclude;
   end
endmodule
